//--- core/lcb_ctrl.v
// Line card bring-up controller: HDLC port control, D-channel arbiter, interface activation
`timescale 1ns/1ps
`include "lcb_regs.vh"
// Contract
// - Bus mode detects collisions; else clear-to-send
// - Power-down stops HDLC logic and its interrupts
// - Power toggling keeps registers and state
// - Downstream needs codes 1010 even, 1011 odd
// - Upstream accepts any pre-processed code
// - Clock mode 3 routes HDLC via arbiter
// - Transmit-pin enable also drives dedicated pin
// - Downstream goes to addressed subscriber
// - Broadcast sends to selected group
// - Upstream only from enabled, per arbiter mode
// - Setup traffic flags invalid data; receiver reset clears
// - Up and down halves configured independently
// - Normal mode enables framing interrupt source
// - Matching framing raises interrupt, sync bit 1
// - PCM drivers off until standby release
// - Subscriber release enables drivers, clock, sync
// - Output select: 1 open-drain, 0 three-state
module lcb_ctrl #(
  parameter NSUB = 32,
  parameter SW = 6,
  parameter DIV = `LCB_DCL_HALF_CYC
) (
  clk,
  resetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  sub_dcl_i,
  sub_fsc_i,
  sub_rxd_i,
  cxd_i,
  serial_rxd_i,
  hdlc_txd,
  hdlc_tx_strobe,
  hdlc_rxd,
  hdlc_rx_strobe,
  hdlc_cts,
  tx_pin_o,
  tx_pin_oe_n,
  sub_txd_o,
  sub_txd_oe_n,
  sub_dcl_o,
  sub_dcl_oe_n,
  sub_fsc_o,
  sub_fsc_oe_n,
  pcm_txd_o,
  pcm_txd_oe_n,
  irq
);
  input wire clk;
  input wire resetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [7:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  input wire sub_dcl_i;
  input wire sub_fsc_i;
  input wire sub_rxd_i;
  input wire cxd_i;
  input wire serial_rxd_i;
  input wire hdlc_txd;
  output reg hdlc_tx_strobe;
  output reg hdlc_rxd;
  output reg hdlc_rx_strobe;
  output wire hdlc_cts;
  output reg tx_pin_o;
  output reg tx_pin_oe_n;
  output reg sub_txd_o;
  output reg sub_txd_oe_n;
  output reg sub_dcl_o;
  output wire sub_dcl_oe_n;
  output reg sub_fsc_o;
  output wire sub_fsc_oe_n;
  output reg pcm_txd_o;
  output wire pcm_txd_oe_n;
  output wire irq;

  localparam integer LAST_I = 2*NSUB-1;
  localparam integer DIV_I = DIV;
  localparam [SW-1:0] LAST = LAST_I[SW-1:0];
  localparam [15:0] DIVC = DIV_I[15:0];

  reg [7:0] cfg1_reg;
  reg [7:0] cfg2_reg;
  reg [7:0] mask_reg;
  reg [7:0] xdc_reg;
  reg [31:0] bcg_reg;
  reg [7:0] amo_reg;
  reg [31:0] dce_reg;
  reg [7:0] operation_mode_reg_reg;
  reg txr_reg;
  reg rxr_reg;
  reg col_reg;
  reg pss_reg;
  reg ida_reg;
  reg pfi_reg;
  reg [4:0] s1_reg;
  reg [4:0] s2_reg;
  reg dcl_d_reg;
  reg [15:0] div_reg;
  reg [SW-1:0] slot_reg;
  reg fs_seen_reg;

  function hit;
    input [7:0] a;
    input [7:0] o;
    begin
      hit = (a == o);
    end
  endfunction

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire pwr = cfg1_reg[`LCB_CFG1_PWR];
  wire busc = cfg1_reg[`LCB_CFG1_BUS];
  wire [1:0] ckm = cfg1_reg[`LCB_CFG1_CM_HI:`LCB_CFG1_CM_LO];
  wire arb_mode = (ckm == `LCB_CLKMODE_ARB);
  wire [1:0] om = operation_mode_reg_reg[`LCB_OM_HI:`LCB_OM_LO];
  wire pcm_standby_release = operation_mode_reg_reg[`LCB_OM_PSB];
  wire sub_if_standby_release = operation_mode_reg_reg[`LCB_OM_CSB];
  wire sub_if_output_select = operation_mode_reg_reg[`LCB_OM_COS];
  wire cko = operation_mode_reg_reg[`LCB_OM_CKO];
  wire dcl_s = s2_reg[0];
  wire fsc_s = s2_reg[1];
  wire rxd_s = s2_reg[2];
  wire cxd_s = s2_reg[3];
  wire srx_s = s2_reg[4];
  wire mapped = hit(paddr, `LCB_OFF_CFG1) || hit(paddr, `LCB_OFF_CFG2) ||
    hit(paddr, `LCB_OFF_CMD) || hit(paddr, `LCB_OFF_STAT) ||
    hit(paddr, `LCB_OFF_INTERRUPT_STATUS) || hit(paddr, `LCB_OFF_MASK) ||
    hit(paddr, `LCB_OFF_XDC) || hit(paddr, `LCB_OFF_BCG) ||
    hit(paddr, `LCB_OFF_AMO) || hit(paddr, `LCB_OFF_DCE) ||
    hit(paddr, `LCB_OFF_OPERATION_MODE_REG) || hit(paddr, `LCB_OFF_CMA);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  wire cmd_wr = wr && hit(paddr, `LCB_OFF_CMD) && pwr;
  wire transmitter_reset_cmd = cmd_wr && pwdata[`LCB_CMD_TRANSMITTER_RESET_CMD];
  wire rres = cmd_wr && pwdata[`LCB_CMD_RRES];

  // Control memory holds code and data per slot
  wire cm_we = wr && hit(paddr, `LCB_OFF_CMA);
  wire [11:0] cm_q;
  lcb_mem #(
    .AW(SW),
    .DW(12)
  ) u_mem (
    .clk(clk),
    .we(cm_we),
    .waddr(pwdata[`LCB_CMA_A_LO+SW-1:`LCB_CMA_A_LO]),
    .wdata({pwdata[`LCB_CMA_C_LO+3:`LCB_CMA_C_LO], pwdata[`LCB_CMA_D_LO+7:`LCB_CMA_D_LO]}),
    .raddr(slot_reg),
    .rdata(cm_q)
  );
  wire [3:0] control_memory_code = cm_q[11:8];
  wire [7:0] cmd = cm_q[7:0];

  // Register writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg1_reg <= `LCB_RST_8;
      cfg2_reg <= `LCB_RST_8;
      mask_reg <= `LCB_RST_8;
      xdc_reg <= `LCB_RST_8;
      bcg_reg <= `LCB_RST_32;
      amo_reg <= `LCB_RST_8;
      dce_reg <= `LCB_RST_32;
      operation_mode_reg_reg <= `LCB_RST_8;
    end else if (wr) begin
      // Each register written on its own; no ordering between halves
      case (paddr)
        `LCB_OFF_CFG1: cfg1_reg <= pwdata[7:0];
        `LCB_OFF_CFG2: cfg2_reg <= pwdata[7:0];
        `LCB_OFF_MASK: mask_reg <= pwdata[7:0];
        `LCB_OFF_XDC: xdc_reg <= pwdata[7:0];
        `LCB_OFF_BCG: bcg_reg <= pwdata;
        `LCB_OFF_AMO: amo_reg <= pwdata[7:0];
        `LCB_OFF_DCE: dce_reg <= pwdata;
        `LCB_OFF_OPERATION_MODE_REG: operation_mode_reg_reg <= pwdata[7:0];
        default: cfg1_reg <= cfg1_reg;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= `LCB_RST_32;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `LCB_OFF_CFG1: prdata <= {24'h000000, cfg1_reg};
        `LCB_OFF_CFG2: prdata <= {24'h000000, cfg2_reg};
        `LCB_OFF_STAT: prdata <= {27'h0000000, pss_reg, col_reg, pwr, rxr_reg, txr_reg};
        `LCB_OFF_INTERRUPT_STATUS: prdata <= {30'h00000000, pfi_reg, ida_reg};
        `LCB_OFF_MASK: prdata <= {24'h000000, mask_reg};
        `LCB_OFF_XDC: prdata <= {24'h000000, xdc_reg};
        `LCB_OFF_BCG: prdata <= bcg_reg;
        `LCB_OFF_AMO: prdata <= {24'h000000, amo_reg};
        `LCB_OFF_DCE: prdata <= dce_reg;
        `LCB_OFF_OPERATION_MODE_REG: prdata <= {24'h000000, operation_mode_reg_reg};
        default: prdata <= `LCB_RST_32;
      endcase
    end
  end

  // Pin synchronisers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
    end else begin
      s1_reg <= {serial_rxd_i, cxd_i, sub_rxd_i, sub_fsc_i, sub_dcl_i};
      s2_reg <= s1_reg;
    end
  end

  // Own clock and frame sync when configured as outputs
  wire div_end = (div_reg == DIVC - 16'h0001);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 16'h0000;
      sub_dcl_o <= 1'b0;
      sub_fsc_o <= 1'b0;
    end else if (cko && sub_if_standby_release) begin
      div_reg <= div_end ? 16'h0000 : div_reg + 16'h0001;
      if (div_end) begin
        sub_dcl_o <= !sub_dcl_o;
        if (!sub_dcl_o) begin
          sub_fsc_o <= (slot_reg == LAST);
        end
      end
    end else begin
      div_reg <= 16'h0000;
      sub_dcl_o <= 1'b0;
      sub_fsc_o <= 1'b0;
    end
  end
  assign sub_dcl_oe_n = !(sub_if_standby_release && cko);
  assign sub_fsc_oe_n = !(sub_if_standby_release && cko);

  wire dcl_now = cko ? sub_dcl_o : dcl_s;
  wire fs_now = cko ? sub_fsc_o : fsc_s;
  wire tick = dcl_now && !dcl_d_reg && pwr;

  // Per-slot decode
  wire [SW-2:0] chan = slot_reg[SW-1:1];
  wire odd = slot_reg[0];
  wire [4:0] ch5 = chan;
  wire sel_ch = xdc_reg[`LCB_XDC_BCT] ? bcg_reg[ch5] : (xdc_reg[4:0] == ch5);
  wire dn_d = arb_mode && odd && (control_memory_code == `LCB_CMC_DN_ODD) && sel_ch;
  wire dn_m = !odd && (control_memory_code == `LCB_CMC_DN_EVEN);
  wire up_pp = odd && control_memory_code[3];
  wire up_ok = up_pp && dce_reg[ch5] && amo_reg[`LCB_AMO_EN];
  wire up_bad = up_pp && !up_ok && !rxd_s;
  wire cts_ok = busc || !cxd_s;
  wire tx_go = dn_d && txr_reg && cts_ok;
  wire dn_bit = tx_go ? hdlc_txd : cmd[0];
  wire dn_act = tx_go || dn_m;

  // Link side: slot counter, sync check and data paths
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dcl_d_reg <= 1'b0;
      slot_reg <= {SW{1'b0}};
      fs_seen_reg <= 1'b0;
      pss_reg <= 1'b0;
      hdlc_rxd <= 1'b1;
      hdlc_rx_strobe <= 1'b0;
      hdlc_tx_strobe <= 1'b0;
      sub_txd_o <= 1'b1;
      sub_txd_oe_n <= 1'b1;
      pcm_txd_o <= 1'b1;
      tx_pin_o <= 1'b1;
      tx_pin_oe_n <= 1'b1;
    end else begin
      dcl_d_reg <= dcl_now;
      hdlc_rx_strobe <= 1'b0;
      hdlc_tx_strobe <= 1'b0;
      if (tick) begin
        slot_reg <= (fs_now || slot_reg == LAST) ? {SW{1'b0}} : slot_reg + 1'b1;
        fs_seen_reg <= 1'b1;
        if (fs_seen_reg) begin
          pss_reg <= fs_now ? (slot_reg == LAST) : (pss_reg && slot_reg != LAST);
        end
        // Open-drain drives low only; three-state drives both levels
        sub_txd_o <= dn_bit;
        sub_txd_oe_n <= !(sub_if_standby_release && dn_act && (!sub_if_output_select || !dn_bit));
        if (arb_mode) begin
          if (up_ok && rxr_reg) begin
            hdlc_rxd <= rxd_s;
            hdlc_rx_strobe <= 1'b1;
            pcm_txd_o <= rxd_s;
          end
        end else begin
          hdlc_rxd <= srx_s;
          hdlc_rx_strobe <= rxr_reg;
        end
        if (tx_go || (!arb_mode && txr_reg)) begin
          hdlc_tx_strobe <= 1'b1;
          tx_pin_o <= hdlc_txd;
        end
        tx_pin_oe_n <= !(cfg2_reg[`LCB_CFG2_TXE] || !arb_mode);
      end
    end
  end
  assign pcm_txd_oe_n = !pcm_standby_release;
  assign hdlc_cts = pwr && !busc && !cxd_s;

  // HDLC state, collision and interrupt flags; set wins over clear
  wire col_ev = tick && busc && tx_go && (cxd_s != hdlc_txd);
  wire ida_ev = tick && arb_mode && up_bad;
  wire pss_chg = tick && fs_seen_reg && (fs_now ? (slot_reg == LAST) != pss_reg : (pss_reg && slot_reg == LAST));
  wire pfi_ev = pss_chg && (om == `LCB_MODE_NORMAL);
  wire pfi_clr = wr && hit(paddr, `LCB_OFF_INTERRUPT_STATUS) && pwdata[`LCB_IS_PFI];
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txr_reg <= 1'b0;
      rxr_reg <= 1'b0;
      col_reg <= 1'b0;
      ida_reg <= 1'b0;
      pfi_reg <= 1'b0;
    end else begin
      if (transmitter_reset_cmd) begin
        txr_reg <= 1'b1;
      end
      if (rres) begin
        rxr_reg <= 1'b1;
      end
      if (col_ev) begin
        col_reg <= 1'b1;
      end else if (transmitter_reset_cmd) begin
        col_reg <= 1'b0;
      end
      if (ida_ev) begin
        ida_reg <= 1'b1;
      end else if (rres) begin
        ida_reg <= 1'b0;
      end
      if (pfi_ev) begin
        pfi_reg <= 1'b1;
      end else if (pfi_clr) begin
        pfi_reg <= 1'b0;
      end
    end
  end

  // HDLC interrupts are withheld while powered down
  assign irq = (pwr && ida_reg && mask_reg[`LCB_IS_IDA]) || (pfi_reg && mask_reg[`LCB_IS_PFI]);
endmodule // lcb_ctrl

//--- core/lcb_regs.vh
// Register offsets, fields, reset values and timing counts of the bring-up controller
`ifndef LCB_REGS_VH
`define LCB_REGS_VH
`define LCB_OFF_CFG1 8'h00
`define LCB_OFF_CFG2 8'h04
`define LCB_OFF_CMD 8'h08
`define LCB_OFF_STAT 8'h0C
`define LCB_OFF_INTERRUPT_STATUS 8'h10
`define LCB_OFF_MASK 8'h14
`define LCB_OFF_XDC 8'h18
`define LCB_OFF_BCG 8'h1C
`define LCB_OFF_AMO 8'h20
`define LCB_OFF_DCE 8'h24
`define LCB_OFF_OPERATION_MODE_REG 8'h28
`define LCB_OFF_CMA 8'h2C
`define LCB_CFG1_PWR 0
`define LCB_CFG1_BUS 1
`define LCB_CFG1_CM_LO 2
`define LCB_CFG1_CM_HI 3
`define LCB_CFG2_TXE 0
`define LCB_CMD_TRANSMITTER_RESET_CMD 0
`define LCB_CMD_RRES 1
`define LCB_ST_TXR 0
`define LCB_ST_RXR 1
`define LCB_ST_PWR 2
`define LCB_ST_COL 3
`define LCB_ST_PSS 4
`define LCB_IS_IDA 0
`define LCB_IS_PFI 1
`define LCB_XDC_BCT 7
`define LCB_AMO_EN 0
`define LCB_OM_LO 0
`define LCB_OM_HI 1
`define LCB_OM_PSB 2
`define LCB_OM_CSB 3
`define LCB_OM_COS 4
`define LCB_OM_CKO 5
`define LCB_CMA_A_LO 0
`define LCB_CMA_C_LO 8
`define LCB_CMA_D_LO 16
`define LCB_RST_8 8'h00
`define LCB_RST_32 32'h00000000
`define LCB_MODE_NORMAL 2'h3
`define LCB_CLKMODE_ARB 2'h3
`define LCB_CMC_DN_EVEN 4'hA
`define LCB_CMC_DN_ODD 4'hB
`define LCB_CLK_MHZ 250
`define LCB_DCL_HALF_NS 80
`define LCB_DCL_HALF_CYC ((`LCB_DCL_HALF_NS * `LCB_CLK_MHZ) / 1000)
`endif

//--- core/lcb_mem.v
// Control memory: one code and data word per time slot, registered read
`timescale 1ns/1ps
module lcb_mem #(
  parameter AW = 6,
  parameter DW = 12
) (
  clk,
  we,
  waddr,
  wdata,
  raddr,
  rdata
);
  input wire clk;
  input wire we;
  input wire [AW-1:0] waddr;
  input wire [DW-1:0] wdata;
  input wire [AW-1:0] raddr;
  output reg [DW-1:0] rdata;
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // lcb_mem

//--- verification/lcb_ctrl_properties.sv
// Port assertions of the bring-up controller
`timescale 1ns/1ps
module lcb_props (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire cxd_i,
  input wire hdlc_cts,
  input wire hdlc_tx_strobe,
  input wire hdlc_rx_strobe,
  input wire tx_pin_oe_n,
  input wire sub_txd_o,
  input wire sub_txd_oe_n,
  input wire sub_dcl_oe_n,
  input wire sub_fsc_oe_n,
  input wire pcm_txd_oe_n,
  input wire irq
);
  reg [3:0] c1_reg;
  reg c2_reg;
  reg [5:0] om_reg;
  reg [1:0] mk_reg;
  // Shadow of the written configuration
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c1_reg <= 4'h0;
      c2_reg <= 1'b0;
      om_reg <= 6'h00;
      mk_reg <= 2'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == 8'h00) c1_reg <= pwdata[3:0];
      if (paddr == 8'h04) c2_reg <= pwdata[0];
      if (paddr == 8'h28) om_reg <= pwdata[5:0];
      if (paddr == 8'h14) mk_reg <= pwdata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_cts_cause: assert property (hdlc_cts |-> c1_reg[0] && !c1_reg[1] && !$past(cxd_i, 2))
    else $error("cts wrong");
  a_pwr_quiet: assert property (!c1_reg[0] && !$past(c1_reg[0]) && !$past(c1_reg[0], 2)
    |-> !hdlc_tx_strobe && !hdlc_rx_strobe) else $error("strobe while down");
  a_tx_pin: assert property ($rose(c2_reg) && c1_reg == 4'hD |-> ##[1:60] !tx_pin_oe_n)
    else $error("tx pin idle");
  a_pcm_oe: assert property (pcm_txd_oe_n == !om_reg[2])
    else $error("pcm enable wrong");
  a_clk_oe: assert property (sub_dcl_oe_n == !(om_reg[3] && om_reg[5]) && sub_fsc_oe_n == sub_dcl_oe_n)
    else $error("clock enable wrong");
  a_sub_enable: assert property ($fell(sub_txd_oe_n) |-> $past(om_reg[3]))
    else $error("driver without release");
  a_open_drain: assert property (($fell(sub_txd_oe_n) || !sub_txd_oe_n && $changed(sub_txd_o))
    && $past(om_reg[4]) |-> !sub_txd_o) else $error("open drain drives high");
  a_irq_mask: assert property (irq |-> mk_reg != 2'h0)
    else $error("irq unmasked");
endmodule // lcb_props

//--- verification/lcb_sub_model.sv
// Subscriber side model: link clock, frame sync and upstream data
`timescale 1ns/1ps
module lcb_sub_model (
  input wire fs_en,
  input wire up_bit,
  output reg subscriber_data_clock,
  output reg subscriber_frame_sync,
  output reg rxd
);
  integer n;
  initial begin
    subscriber_data_clock = 1'b0;
    subscriber_frame_sync = 1'b0;
    rxd = 1'b1;
    n = 0;
    #1.3;
    forever #80 subscriber_data_clock = ~subscriber_data_clock;
  end
  always @(posedge subscriber_data_clock) n <= (n == 63) ? 0 : n + 1;
  // Sync marks the frame wrap, data changes on the falling edge
  always @(negedge subscriber_data_clock) begin
    subscriber_frame_sync <= fs_en && n == 63;
    rxd <= up_bit;
  end
endmodule // lcb_sub_model

//--- verification/testbench.sv
// Testbench of the line card bring-up controller
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h00000000;
  reg cxd_i = 1'b0;
  reg serial_rxd_i = 1'b1;
  reg hdlc_txd = 1'b0;
  reg fs_en = 1'b1;
  reg up_bit = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, sub_dcl_i, sub_fsc_i, sub_rxd_i, hdlc_tx_strobe, hdlc_rxd, hdlc_rx_strobe, hdlc_cts;
  wire tx_pin_o, tx_pin_oe_n, sub_txd_o, sub_txd_oe_n, sub_dcl_o, sub_dcl_oe_n, sub_fsc_o, sub_fsc_oe_n;
  wire pcm_txd_o, pcm_txd_oe_n, irq;
  integer n_errors = 0;
  integer checks = 0;
  integer txs = 0;
  integer rxs = 0;
  integer drv = 0;
  integer dh = 0;
  integer fh = 0;
  integer i;
  reg [31:0] rv;
  reg ev;
  always #2 clk = ~clk;
  lcb_ctrl uut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sub_dcl_i, .sub_fsc_i, .sub_rxd_i, .cxd_i, .serial_rxd_i, .hdlc_txd, .hdlc_tx_strobe, .hdlc_rxd,
    .hdlc_rx_strobe, .hdlc_cts, .tx_pin_o, .tx_pin_oe_n, .sub_txd_o, .sub_txd_oe_n, .sub_dcl_o,
    .sub_dcl_oe_n, .sub_fsc_o, .sub_fsc_oe_n, .pcm_txd_o, .pcm_txd_oe_n, .irq);
  lcb_sub_model sub (.fs_en, .up_bit, .subscriber_data_clock(sub_dcl_i), .subscriber_frame_sync(sub_fsc_i), .rxd(sub_rxd_i));
  always @(posedge clk) begin
    if (hdlc_tx_strobe === 1'b1) txs = txs + 1;
    if (hdlc_rx_strobe === 1'b1) rxs = rxs + 1;
    if (sub_txd_oe_n === 1'b0) drv = drv + 1;
    if (sub_dcl_o === 1'b1) dh = dh + 1;
    if (sub_fsc_o === 1'b1) fh = fh + 1;
  end
  task xf(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      @(posedge clk);
      while (pready !== 1'b1 && k < 50) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k >= 50) begin
        n_errors = n_errors + 1;
        $display("wrong value pready exp 1 got 0");
      end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("wrong value %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    xf(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] e, input string nm);
    begin
      xf(1'b0, a, 32'h00000000);
      chk(nm, e, rv);
    end
  endtask
  // Let a setting settle, then count strobes over exactly 64 link ticks
  task frame;
    begin
      repeat (2600) @(posedge clk);
      @(negedge clk);
      txs = 0;
      rxs = 0;
      drv = 0;
      dh = 0;
      fh = 0;
      repeat (2560) @(posedge clk);
    end
  endtask
  task done(input string nm);
    $display("test %0s finished", nm);
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_errors = n_errors + 1;
    $display("watchdog expired");
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("pcm_oe", 1, pcm_txd_oe_n);
    chk("dcl_oe", 1, sub_dcl_oe_n);
    // Clear every slot of the control memory to the unassigned code
    for (i = 0; i < 64; i = i + 1) begin
      wr(8'h2C, i);
    end
    wr(8'h08, 32'h3);
    rd(8'h0C, 32'h0, "stat");
    xf(1'b0, 8'h3C, 32'h0);
    chk("err", 1, ev);
    done("reset");
    // Address compares of the HDLC core keep their zero reset value
    wr(8'h00, 32'h0D); // Clock mode 3 only; mode 2 bypasses the slots and strobes HDLC every tick
    wr(8'h08, 32'h3);
    rd(8'h0C, 32'h7, "stat");
    chk("cts", 1, hdlc_cts);
    cxd_i <= 1'b1;
    repeat (3) @(posedge clk);
    chk("cts", 0, hdlc_cts);
    cxd_i <= 1'b0;
    wr(8'h00, 32'h0F);
    chk("cts", 0, hdlc_cts);
    wr(8'h00, 32'h0D);
    wr(8'h04, 32'h1);
    repeat (100) @(posedge clk);
    chk("txpin_oe", 0, tx_pin_oe_n);
    wr(8'h00, 32'h0C);
    rd(8'h0C, 32'h3, "stat");
    rd(8'h04, 32'h1, "cfg2");
    wr(8'h00, 32'h0D);
    done("power");
    wr(8'h2C, 32'h00F10A06);
    wr(8'h2C, 32'h00000B07);
    wr(8'h18, 32'h05);
    frame;
    chk("tx", 0, txs);
    chk("drv", 0, drv);
    wr(8'h18, 32'h03);
    frame;
    chk("tx", 1, txs);
    chk("tx_pin", 0, tx_pin_o);
    wr(8'h1C, 32'h08);
    wr(8'h18, 32'h85);
    frame;
    chk("tx", 1, txs);
    wr(8'h00, 32'h0F);
    cxd_i <= 1'b1;
    frame;
    rd(8'h0C, 32'h1F, "stat");
    wr(8'h00, 32'h0D);
    cxd_i <= 1'b0;
    wr(8'h08, 32'h1);
    rd(8'h0C, 32'h17, "stat");
    done("down");
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h0);
    frame;
    chk("rx", 0, rxs);
    chk("hdlc_rxd", 1, hdlc_rxd);
    rd(8'h10, 32'h1, "interrupt_status");
    wr(8'h24, 32'h08);
    frame;
    chk("rx", 1, rxs);
    chk("hdlc_rxd", 0, hdlc_rxd);
    chk("pcm_txd", 0, pcm_txd_o);
    wr(8'h2C, 32'h00000909);
    wr(8'h24, 32'h10);
    frame;
    chk("rx", 1, rxs);
    up_bit <= 1'b1;
    repeat (2600) @(posedge clk);
    wr(8'h08, 32'h2);
    rd(8'h10, 32'h0, "interrupt_status");
    done("up");
    wr(8'h14, 32'h2);
    wr(8'h28, 32'h3);
    fs_en <= 1'b0;
    repeat (3000) @(posedge clk);
    rd(8'h10, 32'h2, "interrupt_status");
    chk("irq", 1, irq);
    wr(8'h10, 32'h2);
    chk("irq", 0, irq);
    fs_en <= 1'b1;
    repeat (5400) @(posedge clk);
    rd(8'h0C, 32'h17, "stat");
    rd(8'h10, 32'h2, "interrupt_status");
    chk("irq", 1, irq);
    wr(8'h14, 32'h0);
    chk("irq", 0, irq);
    done("mode");
    wr(8'h28, 32'h1F);
    chk("pcm_oe", 0, pcm_txd_oe_n);
    chk("dcl_oe", 1, sub_dcl_oe_n);
    frame;
    chk("drv", 40, drv);
    wr(8'h28, 32'h0F);
    frame;
    chk("drv", 80, drv);
    wr(8'h28, 32'h3F);
    chk("dcl_oe", 0, sub_dcl_oe_n);
    chk("fsc_oe", 0, sub_fsc_oe_n);
    frame;
    chk("dcl", 1280, dh);
    chk("fsc", 40, fh);
    chk("tx", 1, txs);
    done("drivers");
    print_verdict;
  end
endmodule // testbench
bind lcb_ctrl lcb_props u_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .cxd_i, .hdlc_cts,
  .hdlc_tx_strobe, .hdlc_rx_strobe, .tx_pin_oe_n, .sub_txd_o, .sub_txd_oe_n, .sub_dcl_oe_n, .sub_fsc_oe_n,
  .pcm_txd_oe_n, .irq);
